// [hdl/bisr_pkg.sv]
package bisr_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses, one aligned word each)
  localparam logic [11:0] OFS_CAP_INFO = 12'h130;
  localparam logic [11:0] OFS_STAT_CTRL = 12'h134;
  localparam logic [11:0] OFS_CAUSE = 12'h138;
  localparam logic [11:0] OFS_MASK = 12'h13C;
  localparam logic [11:0] OFS_HOST_FIRST = 12'h148;
  localparam logic [11:0] OFS_HOST_LAST = 12'h15C;

  ////////////////////////////////////////////////////////////////////////////
  // Capability word fields
  localparam int CAP_SECOND_RATE_BIT = 0;
  localparam int CAP_HOST_PORT_BIT = 1;
  localparam int CAP_UPCONFIG_BIT = 2;
  localparam int CAP_BUS_BITS_LSB = 16;
  localparam int CAP_BUS_BITS_W = 3;
  localparam logic [4:0] CFG_WINDOW_BASE_BITS = 5'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Status and control word fields
  localparam int SC_PENDING_BIT = 0;
  localparam int SC_GLOBAL_DIS_BIT = 8;
  localparam int SC_CLR_WRITABLE_BIT = 16;
  localparam int SC_RO_WRITABLE_BIT = 17;
  localparam logic [31:0] SC_WRITABLE_MASK = 32'h0003_0100;
  localparam logic [31:0] SC_RESET = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt cause and mask fields
  localparam int CAUSE_ERR_COR_BIT = 9;
  localparam int CAUSE_ERR_NONFATAL_BIT = 10;
  localparam int CAUSE_ERR_FATAL_BIT = 11;
  localparam logic [31:0] CAUSE_IMPL_MASK = 32'h1FF3_0FEF;
  localparam logic [31:0] CAUSE_ERR_MSG_MASK = 32'h0000_0E00;
  localparam logic [31:0] CAUSE_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Word-aligned match; the two byte bits are ignored
  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] ofs);
    addr_hit = (addr[11:2] == ofs[11:2]);
  endfunction

  function automatic logic addr_in_range(input logic [11:0] addr, input logic [11:0] lo,
                                         input logic [11:0] hi);
    addr_in_range = (addr[11:2] >= lo[11:2]) && (addr[11:2] <= hi[11:2]);
  endfunction

endpackage

// [hdl/bisr_cause.sv]
`timescale 1ns/1ps
module bisr_cause (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [31:0] event_in,
  input wire logic wr_in,
  input wire logic [31:0] wdata_in,
  input wire logic raw_write_in,
  input wire logic err_queue_empty_in,
  output logic [31:0] cause_out
);

  typedef struct packed {
    logic [31:0] cause;
  } bisr_cause_st_t;

  bisr_cause_st_t st_q;
  bisr_cause_st_t st_d;

  always_comb
  begin
    logic [31:0] clr;
    logic [31:0] base;
    clr = wdata_in & bisr_pkg::CAUSE_IMPL_MASK;
    // Error-message causes only clear once the host error queue is drained
    if (!err_queue_empty_in)
    begin
      clr = clr & ~bisr_pkg::CAUSE_ERR_MSG_MASK;
    end
    base = st_q.cause;
    if (wr_in)
    begin
      if (raw_write_in)
      begin
        base = wdata_in & bisr_pkg::CAUSE_IMPL_MASK;
      end
      else
      begin
        base = st_q.cause & ~clr;
      end
    end
    st_d = st_q;
    // Set wins over clear, so no event is lost in a clearing cycle
    st_d.cause = base | (event_in & bisr_pkg::CAUSE_IMPL_MASK);
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st_q.cause <= bisr_pkg::CAUSE_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign cause_out = st_q.cause;

endmodule

// [hdl/bisr_regs.sv]
// Operation
// - Capability word fixed at build, writes ignored
// - Capability bit 0 shows second-rate support
// - Capability bit 1 shows host port, enables registers
// - Capability bit 2 shows upward width reconfiguration
// - Bits 18:16 give config window bus bits
// - Status bit 0 pending flag reads zero
// - Global disable blocks interrupt, causes still set
// - Control bit 16 makes clear-bits directly writable
// - Control bit 17 opens read-only registers for writing; here it only drives READONLY_WRITABLE_OUT
// - Write one clears cause, error causes only once the error queue is empty
// - Cause drives interrupt only when mask set
// - Error causes at bits 9, 10, 11
// - Mask one enables cause, resets to zero
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module bisr_regs #(
  parameter bit SECOND_RATE_CAPABLE = 1'b0,
  parameter bit HOST_PORT = 1'b0,
  parameter bit UPCONFIG_CAPABLE = 1'b0,
  parameter logic [3:0] CONFIG_WINDOW_BUS_BITS = 4'h0
) (
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [11:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  output logic IRQ_OUT,
  input wire logic [31:0] CAUSE_EVENT_IN,
  input wire logic ERR_QUEUE_EMPTY_IN,
  output logic [11:0] HOST_REGS_ADDR_OUT,
  output logic [31:0] HOST_REGS_WDATA_OUT,
  output logic HOST_REGS_WR_OUT,
  output logic HOST_REGS_RD_OUT,
  input wire logic [31:0] HOST_REGS_RDATA_IN,
  output logic READONLY_WRITABLE_OUT,
  output logic [4:0] CONFIG_WINDOW_ADDR_BITS_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [31:0] rdata;
    logic irq;
    logic [31:0] stat_ctrl;
    logic [31:0] mask;
  } bisr_regs_st_t;

  bisr_regs_st_t st_q;
  bisr_regs_st_t st_d;

  logic [31:0] cause;
  logic [31:0] cap_word;
  logic hit_cap;
  logic hit_sc;
  logic hit_cause;
  logic hit_mask;
  logic hit_host;
  logic cause_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Capability word, constant for the life of the build

  function automatic logic [31:0] build_cap_word();
    logic [31:0] w;
    w = bisr_pkg::ZERO_WORD;
    w[bisr_pkg::CAP_SECOND_RATE_BIT] = SECOND_RATE_CAPABLE;
    w[bisr_pkg::CAP_HOST_PORT_BIT] = HOST_PORT;
    w[bisr_pkg::CAP_UPCONFIG_BIT] = UPCONFIG_CAPABLE;
    // Field is three bits wide, so a count of 8 wraps to zero here
    w[bisr_pkg::CAP_BUS_BITS_LSB +: bisr_pkg::CAP_BUS_BITS_W] =
      CONFIG_WINDOW_BUS_BITS[2:0];
    build_cap_word = w;
  endfunction

  function automatic logic [4:0] window_addr_bits(input logic [3:0] bus_bits);
    if (bus_bits == 4'h0)
    begin
      window_addr_bits = 5'h00;
    end
    else
    begin
      window_addr_bits = bisr_pkg::CFG_WINDOW_BASE_BITS + {1'b0, bus_bits};
    end
  endfunction

  assign cap_word = build_cap_word();
  assign CONFIG_WINDOW_ADDR_BITS_OUT = window_addr_bits(CONFIG_WINDOW_BUS_BITS);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  assign hit_cap = bisr_pkg::addr_hit(ADDR_IN, bisr_pkg::OFS_CAP_INFO);
  assign hit_sc = bisr_pkg::addr_hit(ADDR_IN, bisr_pkg::OFS_STAT_CTRL);
  assign hit_cause = bisr_pkg::addr_hit(ADDR_IN, bisr_pkg::OFS_CAUSE);
  assign hit_mask = bisr_pkg::addr_hit(ADDR_IN, bisr_pkg::OFS_MASK);
  // Host-port window only exists in a host-port build
  assign hit_host = HOST_PORT &&
    bisr_pkg::addr_in_range(ADDR_IN, bisr_pkg::OFS_HOST_FIRST,
                            bisr_pkg::OFS_HOST_LAST);

  assign cause_wr = WR_IN && hit_cause;

  // Host-port registers live outside; strobes pass through on a hit
  assign HOST_REGS_ADDR_OUT = ADDR_IN;
  assign HOST_REGS_WDATA_OUT = WDATA_IN;
  assign HOST_REGS_WR_OUT = WR_IN && hit_host;
  assign HOST_REGS_RD_OUT = RD_IN && hit_host;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt cause bank

  bisr_cause u_cause (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .event_in(CAUSE_EVENT_IN),
    .wr_in(cause_wr),
    .wdata_in(WDATA_IN),
    .raw_write_in(st_q.stat_ctrl[bisr_pkg::SC_CLR_WRITABLE_BIT]),
    .err_queue_empty_in(ERR_QUEUE_EMPTY_IN),
    .cause_out(cause)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [31:0] masked;
    masked = cause & st_q.mask;
    st_d = st_q;

    if (WR_IN && hit_sc)
    begin
      // Pending flag and reserved bits stay zero
      st_d.stat_ctrl = WDATA_IN & bisr_pkg::SC_WRITABLE_MASK;
    end
    if (WR_IN && hit_mask)
    begin
      st_d.mask = WDATA_IN & bisr_pkg::CAUSE_IMPL_MASK;
    end

    // One cycle of latency in exchange for a glitch-free line
    st_d.irq = (|masked) && !st_q.stat_ctrl[bisr_pkg::SC_GLOBAL_DIS_BIT];

    // Read data stand only in the cycle after the strobe
    st_d.rdata = bisr_pkg::ZERO_WORD;
    if (RD_IN)
    begin
      if (hit_cap)
      begin
        st_d.rdata = cap_word;
      end
      else if (hit_sc)
      begin
        st_d.rdata = st_q.stat_ctrl;
      end
      else if (hit_cause)
      begin
        st_d.rdata = cause;
      end
      else if (hit_mask)
      begin
        st_d.rdata = st_q.mask;
      end
      else if (hit_host)
      begin
        st_d.rdata = HOST_REGS_RDATA_IN;
      end
      else
      begin
        st_d.rdata = bisr_pkg::ZERO_WORD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge REF_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      st_q.rdata <= bisr_pkg::ZERO_WORD;
      st_q.irq <= 1'b0;
      st_q.stat_ctrl <= bisr_pkg::SC_RESET;
      st_q.mask <= bisr_pkg::MASK_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign RDATA_OUT = st_q.rdata;
  assign IRQ_OUT = st_q.irq;
  // Read-only override is honoured by the apertures outside this bank
  assign READONLY_WRITABLE_OUT = st_q.stat_ctrl[bisr_pkg::SC_RO_WRITABLE_BIT];

endmodule

// [tb/bisr_regs_monitor.sv]
`timescale 1ns/1ps
module bisr_regs_monitor #(
  parameter bit HOST_PORT = 1'b0,
  parameter logic [3:0] CONFIG_WINDOW_BUS_BITS = 4'h0
) (
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [11:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic IRQ_OUT,
  input wire logic HOST_REGS_RD_OUT,
  input wire logic HOST_REGS_WR_OUT,
  input wire logic [11:0] HOST_REGS_ADDR_OUT,
  input wire logic [31:0] HOST_REGS_WDATA_OUT,
  input wire logic READONLY_WRITABLE_OUT,
  input wire logic [4:0] CONFIG_WINDOW_ADDR_BITS_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence s_ctrl_wr;
    WR_IN && ADDR_IN[11:2] == 10'h04D;
  endsequence
  sequence s_dis_wr;
    WR_IN && ADDR_IN[11:2] == 10'h04D && WDATA_IN[8];
  endsequence
  sequence s_mask_off;
    WR_IN && ADDR_IN[11:2] == 10'h04F && WDATA_IN == 32'h0000_0000;
  endsequence
  ////////////////////////////////////////
  a_disable_quiet: assert property (s_dis_wr |-> ##2 !IRQ_OUT)
    else $error("interrupt high under global disable");
  a_mask_quiet: assert property (s_mask_off |-> ##2 !IRQ_OUT)
    else $error("interrupt high with mask clear");
  a_irq_reset: assert property ($fell(SYS_RST_IN) |-> !IRQ_OUT [*2])
    else $error("interrupt high after reset");
  a_pending_zero: assert property (RD_IN && ADDR_IN[11:2] == 10'h04D |=> !RDATA_OUT[0])
    else $error("pending flag read as one");
  a_unmapped_zero: assert property (RD_IN && ADDR_IN[11:8] == 4'h2 |=> RDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  a_host_fwd: assert property (RD_IN && ADDR_IN == 12'h148 |-> HOST_REGS_RD_OUT == HOST_PORT)
    else $error("host read strobe wrong");
  a_host_wr: assert property (WR_IN && ADDR_IN[11:2] == 10'h055 |-> HOST_REGS_WR_OUT == HOST_PORT
    && HOST_REGS_ADDR_OUT == ADDR_IN && HOST_REGS_WDATA_OUT == WDATA_IN)
    else $error("host write not forwarded");
  a_cfg_bits: assert property (CONFIG_WINDOW_ADDR_BITS_OUT == (CONFIG_WINDOW_BUS_BITS == 4'h0 ?
    5'h00 : 5'h14 + {1'b0, CONFIG_WINDOW_BUS_BITS}))
    else $error("window address bits wrong");
  a_ro_flag: assert property (s_ctrl_wr |=> READONLY_WRITABLE_OUT == $past(WDATA_IN[17]))
    else $error("read-only writable flag wrong");
endmodule
bind bisr_regs bisr_regs_monitor #(.HOST_PORT(HOST_PORT),
  .CONFIG_WINDOW_BUS_BITS(CONFIG_WINDOW_BUS_BITS)) i_bisr_regs_monitor (.*);

// [tb/test_bisr_regs.sv]
`timescale 1ns/1ps
module test_bisr_regs;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] ev_s = 32'h0;
  logic qe = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic ro;
  logic [4:0] wbits;
  int errors = 0;
  int checked = 0;
  // Host port on so the forwarded range is reachable
  bisr_regs #(.SECOND_RATE_CAPABLE(1'b1), .HOST_PORT(1'b1), .UPCONFIG_CAPABLE(1'b1),
    .CONFIG_WINDOW_BUS_BITS(4'h5)) i_bisr_regs (.REF_CLK_IN(clk), .SYS_RST_IN(rst),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata),
    .IRQ_OUT(irq), .CAUSE_EVENT_IN(ev_s), .ERR_QUEUE_EMPTY_IN(qe), .HOST_REGS_ADDR_OUT(),
    .HOST_REGS_WDATA_OUT(), .HOST_REGS_WR_OUT(), .HOST_REGS_RD_OUT(),
    .HOST_REGS_RDATA_IN(32'h5A5A_C3C3), .READONLY_WRITABLE_OUT(ro),
    .CONFIG_WINDOW_ADDR_BITS_OUT(wbits));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic ev(input logic [31:0] v);
    @(posedge clk);
    ev_s <= v;
    @(posedge clk);
    ev_s <= 32'h0;
  endtask
  // Lets the registered interrupt catch up
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_cap();
    rd(12'h130, 32'h0005_0007);
    wr(12'h130, 32'hFFFF_FFFF);
    rd(12'h130, 32'h0005_0007);
    chk({27'h0, wbits}, 32'h19);
  endtask
  task automatic t_ctrl();
    wr(12'h134, 32'hFFFF_FFFF);
    rd(12'h134, 32'h0003_0100);
    chk({31'h0, ro}, 32'h1);
    wr(12'h134, 32'h0);
  endtask
  // Error causes must refuse a clear while the queue holds entries
  task automatic t_cause();
    ev(32'h0000_0E11);
    rd(12'h138, 32'h0000_0E01);
    wr(12'h138, 32'h0000_0E01);
    rd(12'h138, 32'h0000_0E00);
    rd(12'h154, 32'h5A5A_C3C3);
    wr(12'h154, 32'h5A5A_C3C3);
    rd(12'h148, 32'h5A5A_C3C3);
    @(posedge clk);
    qe <= 1'b1;
    wr(12'h138, 32'h0000_0E00);
    rd(12'h138, 32'h0);
  endtask
  task automatic t_irq();
    rd(12'h13C, 32'h0);
    ev(32'h0010_0000);
    step();
    chk({31'h0, irq}, 32'h0);
    wr(12'h13C, 32'h0010_0000);
    step();
    chk({31'h0, irq}, 32'h1);
    wr(12'h134, 32'h0000_0100);
    step();
    chk({31'h0, irq}, 32'h0);
    ev(32'h0020_0000);
    rd(12'h138, 32'h0030_0000);
    wr(12'h134, 32'h0);
    step();
    chk({31'h0, irq}, 32'h1);
    wr(12'h138, 32'h0010_0000);
    step();
    chk({31'h0, irq}, 32'h0);
    wr(12'h13C, 32'h0);
  endtask
  task automatic t_raw();
    wr(12'h134, 32'h0001_0000);
    wr(12'h138, 32'hFFFF_FFFF);
    rd(12'h138, 32'h1FF3_0FEF);
    wr(12'h138, 32'h0);
    rd(12'h138, 32'h0);
    wr(12'h134, 32'h0);
    rd(12'h148, 32'h5A5A_C3C3);
    rd(12'h200, 32'h0);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_cap();
    t_ctrl();
    t_cause();
    t_irq();
    t_raw();
    end_sim();
  end
  initial
  begin
    #20000;
    errors++;
    end_sim();
  end
endmodule
